//--- hw/ovp_pkg.sv
// shared types and constants for the overvoltage protection stages
// assumes a single 100 MHz processing clock and magnitudes from an external front end
package ovp_pkg;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_US       = 1000;
  localparam int TICK_CYCLES   = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_W        = 17;

  // ---------------------------------------------------------------------------
  // widths and path layout
  // ---------------------------------------------------------------------------
  localparam int VW        = 16;
  localparam int ACC_W     = 33;
  localparam int NPH       = 3;
  localparam int NPATH     = 8;
  localparam int NSTAGE    = 4;
  localparam int OV1_BASE  = 0;
  localparam int OV2_BASE  = 3;
  localparam int COV1_IDX  = 6;
  localparam int COV2_IDX  = 7;
  localparam int COEF_FRAC = 14;
  localparam int VR_W      = 20;
  localparam int SQ_W      = 42;
  localparam int RT_W      = 21;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [TICK_W-1:0] TICK_CNT_RST = 17'h00000;
  localparam logic [ACC_W-1:0]  ACC_RST      = 33'h000000000;
  localparam logic [VW-1:0]     VMAG_RST     = 16'h0000;
  localparam logic [VR_W-1:0]   VR_RST       = 20'h00000;

  // ---------------------------------------------------------------------------
  // types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {CURVE_DISABLED, CURVE_DT, CURVE_IDMT} curve_e;

  typedef logic [VW-1:0]          volt_t;
  typedef logic [NPH-1:0][VW-1:0] volt3_t;

  typedef struct packed {
    logic         three_phase;
    logic [VW-1:0] vset;
    logic [15:0]  delay_ticks;
    logic [15:0]  tms_ticks;
  } stage_cfg_s;

  typedef struct packed {
    logic signed [15:0] re;
    logic signed [15:0] im;
  } cplx_s;

  typedef struct packed {
    logic [NPH-1:0] start_ph;
    logic [NPH-1:0] trip_ph;
    logic           start;
    logic           trip;
  } stage_out_s;

  typedef struct packed {
    logic [TICK_W-1:0]            tick_cnt;
    logic                         tick;
    logic [NPATH-1:0][ACC_W-1:0]  acc;
    logic [NPATH-1:0]             path_start;
    logic [NPATH-1:0]             path_trip;
    logic signed [VR_W-1:0]       vr_re;
    logic signed [VR_W-1:0]       vr_im;
    logic [VW-1:0]                vr_mag;
    stage_out_s                   ov1;
    stage_out_s                   ov2;
    stage_out_s                   cov1;
    stage_out_s                   cov2;
  } ovp_state_s;

endpackage : ovp_pkg

//--- hw/overvoltage_protection_stages.sv
// two phase overvoltage stages and two compensated (remote end) overvoltage stages
// assumes magnitudes and positive sequence phasors arrive synchronous to clk_i
//
// Overview of operation
// - two phase stages, each with its own threshold and delay settings
// - phase stage one runs inverse time or definite time per curve select
// - inverse delay equals multiplier over (measured over threshold minus one)
// - measurement mode picks phase-neutral or phase-phase magnitudes
// - no timer hold: elapsed time is dropped when start falls
// - phase stage two is definite time only, switched by its enable
// - per-phase start whenever that phase magnitude exceeds the threshold
// - fast supervision inhibit suppresses all starts
// - stage timer block suppresses trips even with start present
// - three independent comparator and timer paths per phase stage, one per compensated stage
// - phase stage start is any phase or all three phases per operate mode
// - phase stage trip combines phase trips under the same operate mode
// - timer held cleared while any enabling input is inactive
// - compensated stages use remote end positive sequence voltage
// - remote voltage from two-port line model, D times Vs minus B times Is
// - compensated stage one is inverse time, definite time or disabled
// - compensated stage two is definite time only, switched by its enable
// - compensated inverse time uses remote voltage over threshold as M
// - compensated stages hold fully independent thresholds and delays
`timescale 1ns/1ps
`default_nettype none

module overvoltage_protection_stages
  import ovp_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // measured quantities
  input  wire volt3_t     ph_n_mag_i,
  input  wire volt3_t     ph_ph_mag_i,
  input  wire cplx_s      vs_pos_i,
  input  wire cplx_s      is_pos_i,
  // line model coefficients
  input  wire cplx_s      line_ad_i,
  input  wire cplx_s      line_b_i,
  // settings
  input  wire logic       meas_phase_phase_i,
  input  wire curve_e     ov_stage1_curve_select_i,
  input  wire logic       ov_stage2_enable_i,
  input  wire curve_e     comp_ov_stage1_curve_select_i,
  input  wire logic       comp_ov_stage2_enable_i,
  input  wire stage_cfg_s ov1_cfg_i,
  input  wire stage_cfg_s ov2_cfg_i,
  input  wire stage_cfg_s cov1_cfg_i,
  input  wire stage_cfg_s cov2_cfg_i,
  // blocking
  input  wire logic       vt_supervision_fast_inhibit_i,
  input  wire logic [NSTAGE-1:0] timer_block_i,
  // results
  output logic            tick_o,
  output volt_t           vr_mag_o,
  output stage_out_s      ov1_o,
  output stage_out_s      ov2_o,
  output stage_out_s      cov1_o,
  output stage_out_s      cov2_o
);

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic combine(input logic three_phase, input logic [NPH-1:0] vec);
    combine = three_phase ? (&vec) : (|vec);
  endfunction : combine

  function automatic logic [RT_W-1:0] isqrt(input logic [SQ_W-1:0] x);
    logic [RT_W-1:0] r;
    logic [RT_W-1:0] rt;
    logic [SQ_W-1:0] sq;
    r = '0;
    for (int i = RT_W - 1; i >= 0; i--) begin
      rt = r | (RT_W'(1) << i);
      sq = SQ_W'({21'h000000, rt} * {21'h000000, rt});
      if (sq <= x) begin
        r = rt;
      end
    end
    isqrt = r;
  endfunction : isqrt

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  ovp_state_s                  st_reg;
  ovp_state_s                  st_next;
  volt3_t                      v_ph;
  volt_t      [NPATH-1:0]      p_v;
  stage_cfg_s [NPATH-1:0]      p_cfg;
  curve_e     [NPATH-1:0]      p_curve;
  logic       [NPATH-1:0]      p_blk;
  logic       [NPATH-1:0]      p_run;
  logic       [ACC_W-1:0]      p_target;
  logic       [ACC_W-1:0]      p_inc;
  logic       [ACC_W-1:0]      p_sum;
  logic signed [33:0]          s_re;
  logic signed [33:0]          s_im;
  logic       [SQ_W-1:0]       mag_sq;
  logic       [RT_W-1:0]       mag_rt;

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    st_next = st_reg;

    // fixed processing tick
    if (st_reg.tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
      st_next.tick_cnt = TICK_CNT_RST;
      st_next.tick     = 1'b1;
    end else begin
      st_next.tick_cnt = st_reg.tick_cnt + TICK_W'(1);
      st_next.tick     = 1'b0;
    end

    // remote end voltage, two cycle pipeline
    s_re = 34'(line_ad_i.re * vs_pos_i.re) - 34'(line_ad_i.im * vs_pos_i.im)
         - 34'(line_b_i.re * is_pos_i.re) + 34'(line_b_i.im * is_pos_i.im);
    s_im = 34'(line_ad_i.re * vs_pos_i.im) + 34'(line_ad_i.im * vs_pos_i.re)
         - 34'(line_b_i.re * is_pos_i.im) - 34'(line_b_i.im * is_pos_i.re);
    st_next.vr_re = s_re[COEF_FRAC+VR_W-1:COEF_FRAC];
    st_next.vr_im = s_im[COEF_FRAC+VR_W-1:COEF_FRAC];
    mag_sq = SQ_W'(st_reg.vr_re * st_reg.vr_re) + SQ_W'(st_reg.vr_im * st_reg.vr_im);
    mag_rt = isqrt(mag_sq);
    st_next.vr_mag = (|mag_rt[RT_W-1:VW]) ? 16'hFFFF : mag_rt[VW-1:0];

    // per path operands
    v_ph = meas_phase_phase_i ? ph_ph_mag_i : ph_n_mag_i;
    for (int p = 0; p < NPH; p++) begin
      p_v[OV1_BASE+p]     = v_ph[p];
      p_cfg[OV1_BASE+p]   = ov1_cfg_i;
      p_curve[OV1_BASE+p] = ov_stage1_curve_select_i;
      p_blk[OV1_BASE+p]   = timer_block_i[0];
      p_v[OV2_BASE+p]     = v_ph[p];
      p_cfg[OV2_BASE+p]   = ov2_cfg_i;
      p_curve[OV2_BASE+p] = ov_stage2_enable_i ? CURVE_DT : CURVE_DISABLED;
      p_blk[OV2_BASE+p]   = timer_block_i[1];
    end
    p_v[COV1_IDX]     = st_reg.vr_mag;
    p_cfg[COV1_IDX]   = cov1_cfg_i;
    p_curve[COV1_IDX] = comp_ov_stage1_curve_select_i;
    p_blk[COV1_IDX]   = timer_block_i[2];
    p_v[COV2_IDX]     = st_reg.vr_mag;
    p_cfg[COV2_IDX]   = cov2_cfg_i;
    p_curve[COV2_IDX] = comp_ov_stage2_enable_i ? CURVE_DT : CURVE_DISABLED;
    p_blk[COV2_IDX]   = timer_block_i[3];

    // comparators and timers
    p_target = ACC_RST;
    p_inc    = ACC_RST;
    p_sum    = ACC_RST;
    for (int p = 0; p < NPATH; p++) begin
      st_next.path_start[p] = (p_curve[p] != CURVE_DISABLED) && !vt_supervision_fast_inhibit_i
                              && (p_v[p] > p_cfg[p].vset);
      p_run[p] = st_next.path_start[p] && !p_blk[p];
      if (p_curve[p] == CURVE_IDMT) begin
        // integrating (v - vset) up to tms * vset gives tms / (M - 1) ticks
        p_target = ACC_W'(p_cfg[p].tms_ticks * p_cfg[p].vset);
        p_inc    = ACC_W'(p_v[p] - p_cfg[p].vset);
      end else begin
        p_target = ACC_W'(p_cfg[p].delay_ticks);
        p_inc    = ACC_W'(1);
      end
      p_sum = st_reg.acc[p] + p_inc;
      if (!p_run[p]) begin
        st_next.acc[p] = ACC_RST;
      end else if (st_reg.tick && (st_reg.acc[p] < p_target)) begin
        st_next.acc[p] = (p_sum > p_target) ? p_target : p_sum;
      end else begin
        st_next.acc[p] = st_reg.acc[p];
      end
      st_next.path_trip[p] = p_run[p] && (st_next.acc[p] >= p_target);
    end

    // stage combination
    st_next.ov1.start_ph  = st_next.path_start[OV1_BASE+:NPH];
    st_next.ov1.trip_ph   = st_next.path_trip[OV1_BASE+:NPH];
    st_next.ov1.start     = combine(ov1_cfg_i.three_phase, st_next.ov1.start_ph);
    st_next.ov1.trip      = combine(ov1_cfg_i.three_phase, st_next.ov1.trip_ph);
    st_next.ov2.start_ph  = st_next.path_start[OV2_BASE+:NPH];
    st_next.ov2.trip_ph   = st_next.path_trip[OV2_BASE+:NPH];
    st_next.ov2.start     = combine(ov2_cfg_i.three_phase, st_next.ov2.start_ph);
    st_next.ov2.trip      = combine(ov2_cfg_i.three_phase, st_next.ov2.trip_ph);
    // compensated stages have one positive sequence path in bit 0
    st_next.cov1.start_ph = {2'b00, st_next.path_start[COV1_IDX]};
    st_next.cov1.trip_ph  = {2'b00, st_next.path_trip[COV1_IDX]};
    st_next.cov1.start    = st_next.path_start[COV1_IDX];
    st_next.cov1.trip     = st_next.path_trip[COV1_IDX];
    st_next.cov2.start_ph = {2'b00, st_next.path_start[COV2_IDX]};
    st_next.cov2.trip_ph  = {2'b00, st_next.path_trip[COV2_IDX]};
    st_next.cov2.start    = st_next.path_start[COV2_IDX];
    st_next.cov2.trip     = st_next.path_trip[COV2_IDX];
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg          <= '0;
      st_reg.tick_cnt <= TICK_CNT_RST;
      st_reg.vr_re    <= VR_RST;
      st_reg.vr_im    <= VR_RST;
      st_reg.vr_mag   <= VMAG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o   = st_reg.tick;
  assign vr_mag_o = st_reg.vr_mag;
  assign ov1_o    = st_reg.ov1;
  assign ov2_o    = st_reg.ov2;
  assign cov1_o   = st_reg.cov1;
  assign cov2_o   = st_reg.cov2;

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_start_on_exceed: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (ov_stage1_curve_select_i != CURVE_DISABLED && !vt_supervision_fast_inhibit_i
     && v_ph[0] > ov1_cfg_i.vset) |=> ov1_o.start_ph[0])
    else $error("phase stage one start missing above threshold");

  a_inhibit_blocks_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    vt_supervision_fast_inhibit_i |=> (st_reg.path_start == '0))
    else $error("start present during fast supervision inhibit");

  a_timer_block_trip: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    timer_block_i[0] |=> (ov1_o.trip_ph == '0 && st_reg.acc[OV1_BASE] == ACC_RST))
    else $error("trip or timer active under timer block");

  a_no_timer_hold: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !st_reg.path_start[OV2_BASE] |-> (st_reg.acc[OV2_BASE] == ACC_RST))
    else $error("elapsed time kept after start dropped");

  a_stage_start_mode: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ##1 ov1_o.start == ($past(ov1_cfg_i.three_phase) ? (&ov1_o.start_ph) : (|ov1_o.start_ph)))
    else $error("stage start not combined per operate mode");

  a_stage_trip_mode: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ##1 ov2_o.trip == ($past(ov2_cfg_i.three_phase) ? (&ov2_o.trip_ph) : (|ov2_o.trip_ph)))
    else $error("stage trip not combined per operate mode");

  a_trip_needs_start: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (st_reg.path_trip & ~st_reg.path_start) == '0)
    else $error("path trip without its own start");

  a_stage2_disabled: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !ov_stage2_enable_i [*2] |-> (ov2_o.start == 1'b0 && ov2_o.trip == 1'b0))
    else $error("disabled phase stage two active");

  a_comp1_disabled: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    comp_ov_stage1_curve_select_i == CURVE_DISABLED |=> (!cov1_o.start && !cov1_o.trip))
    else $error("disabled compensated stage one active");

  a_comp2_disabled: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    !comp_ov_stage2_enable_i |=> (!cov2_o.start && st_reg.acc[COV2_IDX] == ACC_RST))
    else $error("disabled compensated stage two active");

  a_dt_trip_timing: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(st_reg.path_trip[OV2_BASE]) |-> (st_reg.acc[OV2_BASE] >= ACC_W'($past(ov2_cfg_i.delay_ticks))))
    else $error("definite time trip before delay elapsed");

  a_tick_period: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    st_reg.tick |=> !st_reg.tick)
    else $error("processing tick longer than one cycle");

endmodule : overvoltage_protection_stages

`default_nettype wire

//--- dv/ovp_source_model.sv
// partner model: the measuring front end that hands sampled phase magnitudes to the stages
// assumes the bench changes its commands just after rising edges only
`timescale 1ns/1ps
`default_nettype none

module ovp_source_model
  import ovp_pkg::*;
(
  // clock and reset
  input  wire logic   clk_i,
  input  wire logic   rst_n_i,
  // commanded magnitudes
  input  wire volt3_t pn_cmd_i,
  input  wire volt3_t pp_cmd_i,
  // sampled magnitudes
  output var  volt3_t ph_n_mag_o,
  output var  volt3_t ph_ph_mag_o
);
  // ---------------------------------------------------------------------------
  // one sample of delay, as a real front end adds
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_n_mag_o  <= '0;
      ph_ph_mag_o <= '0;
    end else begin
      ph_n_mag_o  <= pn_cmd_i;
      ph_ph_mag_o <= pp_cmd_i;
    end
  end
endmodule : ovp_source_model
`default_nettype wire

//--- dv/overvoltage_protection_stages_tb.sv
// self-checking bench for the overvoltage stages: random and corner stimulus
// assumes the tick is shortened through TICK_CYCLES_P
`timescale 1ns/1ps
`default_nettype none

module overvoltage_protection_stages_tb;
  import ovp_pkg::*;
  localparam int TK = 4;
  logic              clk_i    = 1'b0;
  logic              rst_n_i  = 1'b0;
  volt3_t            pn_cmd   = '0;
  volt3_t            pp_cmd   = '0;
  volt3_t            ph_n_mag;
  volt3_t            ph_ph_mag;
  cplx_s             vs_pos   = '0;
  cplx_s             is_pos   = '0;
  cplx_s             line_ad  = '0;
  cplx_s             line_b   = '0;
  logic              meas_pp  = 1'b0;
  logic              ov2_en   = 1'b0;
  logic              cov2_en  = 1'b0;
  logic              inhibit  = 1'b0;
  curve_e            ov1_curve  = CURVE_DISABLED;
  curve_e            cov1_curve = CURVE_DISABLED;
  stage_cfg_s        ov1_cfg  = '0;
  stage_cfg_s        ov2_cfg  = '0;
  stage_cfg_s        cov1_cfg = '0;
  stage_cfg_s        cov2_cfg = '0;
  logic [NSTAGE-1:0] tblk     = '0;
  logic              tick;
  volt_t             vr_mag;
  stage_out_s        ov1, ov2, cov1, cov2;
  int                failures     = 0;
  int                total_checks = 0;
  logic [31:0]       lfsr         = 32'h88B4B571;
  volt3_t            v;
  logic [15:0]       r;
  int                n_tk         = 0;

  always #5 clk_i = ~clk_i;

  ovp_source_model src (.clk_i(clk_i), .rst_n_i(rst_n_i), .pn_cmd_i(pn_cmd), .pp_cmd_i(pp_cmd),
                        .ph_n_mag_o(ph_n_mag), .ph_ph_mag_o(ph_ph_mag));

  overvoltage_protection_stages #(.TICK_CYCLES_P(TK)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ph_n_mag_i(ph_n_mag), .ph_ph_mag_i(ph_ph_mag),
    .vs_pos_i(vs_pos), .is_pos_i(is_pos), .line_ad_i(line_ad), .line_b_i(line_b),
    .meas_phase_phase_i(meas_pp), .ov_stage1_curve_select_i(ov1_curve), .ov_stage2_enable_i(ov2_en),
    .comp_ov_stage1_curve_select_i(cov1_curve), .comp_ov_stage2_enable_i(cov2_en),
    .ov1_cfg_i(ov1_cfg), .ov2_cfg_i(ov2_cfg), .cov1_cfg_i(cov1_cfg), .cov2_cfg_i(cov2_cfg),
    .vt_supervision_fast_inhibit_i(inhibit), .timer_block_i(tblk), .tick_o(tick), .vr_mag_o(vr_mag),
    .ov1_o(ov1), .ov2_o(ov2), .cov1_o(cov1), .cov2_o(cov2));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic logic [2:0] exp_ph(input volt3_t vv, input volt_t s);
    for (int p = 0; p < 3; p++) exp_ph[p] = vv[p] > s;
  endfunction : exp_ph

  function automatic logic combine(input logic [2:0] b, input logic three);
    return three ? &b : |b;
  endfunction : combine

  task automatic check(input logic [31:0] seen, input logic [31:0] expd, input string msg);
    total_checks++;
    if (seen !== expd) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, expd);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  // cycles from the raise until trip, against a window around d ticks
  task automatic time_trip(input int sel, input int d);
    int n;
    n = 0;
    // sampled on falling edges only, never in the launching time step
    do begin
      @(negedge clk_i);
      n++;
    end while (((sel == 0) ? ov1.trip : cov1.trip) !== 1'b1 && n < 200);
    check(32'(n >= (d - 1) * TK && n <= (d + 1) * TK + 6), 32'h1, "trip delay");
  endtask : time_trip

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    ov1_curve <= CURVE_DT;
    ov2_en <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk_i);
      v = {16'h0400 + 16'(lfsr[6:0]), 16'h0400 + 16'(lfsr[13:7]), (i == 0) ? 16'h0420 : 16'h0400 + 16'(lfsr[20:14])};
      pn_cmd <= v;
      ov1_cfg <= '{lfsr[30], 16'h0420, 16'd50, 16'd2};
      ov2_cfg <= '{lfsr[31], 16'h0440, 16'd50, 16'd2};
      settle(3);
      check(32'(ov1.start_ph), 32'(exp_ph(v, 16'h0420)), "stage one phase starts");
      check(32'(ov1.start), 32'(combine(exp_ph(v, 16'h0420), lfsr[30])), "stage one start");
      check(32'(ov2.start_ph), 32'(exp_ph(v, 16'h0440)), "stage two phase starts");
      check(32'(ov2.start), 32'(combine(exp_ph(v, 16'h0440), lfsr[31])), "stage two start");
    end
    $display("test random comparators done");
    @(posedge clk_i);
    pn_cmd <= {3{16'h0500}};
    ov1_cfg <= '{1'b0, 16'h0420, 16'd2, 16'd2};
    ov2_cfg <= '{1'b0, 16'h0440, 16'd2, 16'd2};
    tblk <= 4'h1;
    settle(4 * TK + 6);
    check(32'(ov1.start), 32'h1, "start under timer block");
    check(32'(ov1.trip), 32'h0, "trip under timer block");
    check(32'(ov2.trip), 32'h1, "other stage trips unblocked");
    check(32'(ov2.trip_ph), 32'h7, "other stage phase trips");
    @(posedge clk_i);
    tblk <= 4'h0;
    inhibit <= 1'b1;
    settle(3);
    check(32'({ov1.start_ph, ov2.start_ph}), 32'h0, "starts under inhibit");
    @(posedge clk_i);
    inhibit <= 1'b0;
    ov1_curve <= CURVE_DISABLED;
    ov2_en <= 1'b0;
    settle(4 * TK);
    check(32'({ov1, ov2}), 32'h0, "disabled stages");
    $display("test blocking done");
    @(posedge clk_i);
    ov1_curve <= CURVE_DT;
    ov1_cfg <= '{1'b0, 16'h0420, 16'd3, 16'd2};
    pn_cmd <= {3{16'h0100}};
    settle(3);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0500}};
    time_trip(0, 3);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0100}};
    settle(3);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0500}};
    settle(2 * TK);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0100}};
    settle(1);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0500}};
    time_trip(0, 3);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0100}};
    settle(3);
    @(posedge clk_i);
    pn_cmd <= {3{16'h0500}};
    settle(2 * TK);
    @(posedge clk_i);
    tblk <= 4'h1;
    settle(1);
    @(posedge clk_i);
    tblk <= 4'h0;
    time_trip(0, 3);
    @(posedge clk_i);
    ov1_cfg <= '{1'b1, 16'h0420, 16'd1, 16'd2};
    pn_cmd <= {16'h0100, 16'h0100, 16'h0500};
    settle(3 * TK + 6);
    check(32'(ov1.trip_ph), 32'h1, "single phase trip");
    check(32'(ov1.trip), 32'h0, "three phase trip mode");
    @(posedge clk_i);
    pp_cmd <= {3{16'h0500}};
    pn_cmd <= {3{16'h0100}};
    settle(3);
    check(32'(ov1.start_ph), 32'h0, "phase neutral mode");
    @(posedge clk_i);
    meas_pp <= 1'b1;
    settle(3);
    check(32'(ov1.start_ph), 32'h7, "phase phase mode");
    @(posedge clk_i);
    meas_pp <= 1'b0;
    ov1_curve <= CURVE_IDMT;
    ov1_cfg <= '{1'b0, 16'd1000, 16'd50, 16'd2};
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      pn_cmd <= {3{16'h0100}};
      settle(3);
      @(posedge clk_i);
      pn_cmd[0] <= (k == 0) ? 16'd1500 : 16'd3000;
      time_trip(0, (k == 0) ? 4 : 1);
    end
    // one tick pulse per period of the shortened tick
    n_tk = 0;
    repeat (4 * TK) begin
      @(negedge clk_i);
      n_tk += int'(tick === 1'b1);
    end
    check(32'(n_tk), 32'd4, "ticks in four periods");
    $display("test timers done");
    @(posedge clk_i);
    line_ad <= '{16'sd16384, 16'sd0};
    line_b <= '{16'sd16384, 16'sd0};
    is_pos <= '{16'sd100, 16'sd0};
    cov1_curve <= CURVE_DT;
    cov2_en <= 1'b1;
    cov1_cfg <= '{1'b0, 16'h0500, 16'd50, 16'd2};
    cov2_cfg <= '{1'b0, 16'h0700, 16'd50, 16'd2};
    for (int i = 0; i < 20; i++) begin
      lfsr = lfsr_next(lfsr);
      r = 16'h0200 + 16'(lfsr[10:0]);
      @(posedge clk_i);
      vs_pos.re <= r;
      settle(5);
      check(32'(vr_mag), 32'(r - 16'd100), "remote magnitude");
      check(32'(cov1.start), 32'((r - 16'd100) > 16'h0500), "compensated start one");
      check(32'(cov2.start), 32'((r - 16'd100) > 16'h0700), "compensated start two");
      check(32'(cov1.start_ph[2:1]), 32'h0, "unused phase bits");
    end
    @(posedge clk_i);
    cov1_curve <= CURVE_DISABLED;
    cov2_en <= 1'b0;
    vs_pos.re <= 16'sd3000;
    settle(6);
    check(32'({cov1, cov2}), 32'h0, "compensated disabled");
    @(posedge clk_i);
    cov1_curve <= CURVE_IDMT;
    cov1_cfg <= '{1'b0, 16'd1000, 16'd50, 16'd2};
    vs_pos.re <= 16'sd200;
    settle(6);
    @(posedge clk_i);
    vs_pos.re <= 16'sd1600;
    time_trip(1, 4);
    // quadrature coefficients: remote voltage -300 + j400, magnitude 500
    @(posedge clk_i);
    line_ad <= '{16'sd0, 16'sd16384};
    line_b <= '{16'sd0, 16'sd16384};
    is_pos <= '{16'sd0, -16'sd300};
    vs_pos <= '{16'sd400, 16'sd0};
    settle(5);
    check(32'(vr_mag), 32'd500, "remote magnitude quadrature");
    $display("test compensated done");
    close_out();
  end
endmodule : overvoltage_protection_stages_tb
`default_nettype wire
